/* File: rtl/sst_pkg.sv */
/*
 Shared constants and types of the status event tree: register map,
 field codes, reset values, event pool indices and the carrier structs.
 Assumes a single 100 MHz clock domain and a plain strobe register port.
*/
package sst_pkg;

	localparam int SST_W = 15;
	typedef logic [14:0] sst_bits_t;

	// Per-node register view
	typedef struct packed {
		sst_bits_t event_r;
		sst_bits_t cond;
		sst_bits_t enable;
		sst_bits_t ptr;
		sst_bits_t ntr;
	} sst_node_s;

	// Per-node configuration write
	typedef struct packed {
		logic wr;
		logic [2:0] fld;
		sst_bits_t data;
	} sst_cfg_s;

	// Field offsets inside a node window
	localparam logic [2:0] SST_FLD_EVENT = 3'h0;
	localparam logic [2:0] SST_FLD_COND = 3'h1;
	localparam logic [2:0] SST_FLD_ENABLE = 3'h2;
	localparam logic [2:0] SST_FLD_PTR = 3'h3;
	localparam logic [2:0] SST_FLD_NTR = 3'h4;

	// Register map (byte offsets on the register port)
	localparam logic [7:0] SST_NODE_OPER = 8'h00;
	localparam logic [7:0] SST_NODE_OPER_INST = 8'h08;
	localparam logic [7:0] SST_NODE_GCLO = 8'h10;
	localparam logic [7:0] SST_NODE_QUES = 8'h18;
	localparam logic [7:0] SST_NODE_QUES_INST = 8'h20;
	localparam logic [7:0] SST_ADDR_QUEUE_NEXT = 8'h28;
	localparam logic [7:0] SST_ADDR_CMD = 8'h29;
	localparam logic [7:0] SST_ADDR_QFILT = 8'h30;
	localparam logic [7:0] SST_ADDR_OPER_MAP = 8'h40;
	localparam logic [7:0] SST_ADDR_QUES_MAP = 8'h50;

	// Command register bits
	localparam int SST_CMD_CLS = 0;
	localparam int SST_CMD_PRESET = 1;

	// Reset values
	localparam sst_bits_t SST_EN_RST = 15'h7fff;
	localparam sst_bits_t SST_PTR_RST = 15'h7fff;
	localparam sst_bits_t SST_NTR_RST = 15'h0000;
	localparam sst_bits_t SST_INST_PTR_RST = 15'h7fff;
	localparam sst_bits_t SST_INST_NTR_RST = 15'h7fff;

	localparam int SST_SLOT_BIT = 13;

	// Event pool feeding the top-level map
	localparam logic [5:0] SST_POOL_OPER = 6'h00;
	localparam logic [5:0] SST_POOL_QUES = 6'h0f;
	localparam logic [5:0] SST_POOL_OPER_INST = 6'h1e;
	localparam logic [5:0] SST_POOL_QUES_INST = 6'h1f;
	localparam logic [5:0] SST_POOL_GCLO = 6'h20;

	// Reporting queue
	localparam int SST_QDEPTH = 8;
	localparam int SST_QFILT = 4;
	localparam int SST_QCODE_W = 16;
	localparam logic [15:0] SST_QEMPTY_CODE = 16'h0000;

	// Power-up source of a top-level bit
	function automatic logic [5:0] sst_map_rst(input logic ques, input int b);
		logic [5:0] base;
		base = ques ? SST_POOL_QUES : SST_POOL_OPER;
		if (b == SST_SLOT_BIT)
			return ques ? SST_POOL_QUES_INST : SST_POOL_OPER_INST;
		return base + 6'(b);
	endfunction

endpackage

/* File: rtl/sst_node.sv */
/*
 One status node: condition, transition filters, latched events,
 enable mask and summary. Assumes condition inputs already synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module sst_node #(
	parameter sst_pkg::sst_bits_t PTR_RST = sst_pkg::SST_PTR_RST,
	parameter sst_pkg::sst_bits_t NTR_RST = sst_pkg::SST_NTR_RST
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Monitored conditions
	input wire sst_pkg::sst_bits_t cond,
	// Software control
	input wire sst_pkg::sst_cfg_s cfg,
	input wire logic rd_evt,
	input wire logic cls,
	input wire logic preset,
	// State
	output var sst_pkg::sst_node_s view,
	output logic summary
);
	import sst_pkg::*;

	sst_bits_t prev_q, evt_q, evt_d, en_q, ptr_q, ntr_q;
	sst_bits_t rise, fall, set_bits;
	logic clr;

	assign rise = cond & ~prev_q & ptr_q; // [R04]
	assign fall = ~cond & prev_q & ntr_q; // [R05]
	assign set_bits = rise | fall;
	assign clr = rd_evt | cls; // [R01] [R16]
	// A new event in the clearing cycle survives
	assign evt_d = (clr ? '0 : evt_q) | set_bits;
	assign summary = |(evt_q & en_q); // [R03] [R20]
	assign view = '{event_r: evt_q, cond: cond, enable: en_q, ptr: ptr_q, ntr: ntr_q};

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			prev_q <= '0;
			evt_q <= '0;
		end
		else
		begin
			prev_q <= cond;
			evt_q <= evt_d;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			en_q <= SST_EN_RST;
			ptr_q <= PTR_RST;
			ntr_q <= NTR_RST;
		end
		else if (preset)
			en_q <= SST_EN_RST; // [R11]
		else if (cfg.wr)
		begin
			if (cfg.fld == SST_FLD_ENABLE)
				en_q <= cfg.data;
			if (cfg.fld == SST_FLD_PTR)
				ptr_q <= cfg.data;
			if (cfg.fld == SST_FLD_NTR)
				ntr_q <= cfg.data;
		end
	end

	a_evt_rise_set: assert property (@(posedge clk_sys) disable iff (!resetn) // [R04]
		(|(cond & ~prev_q & ptr_q)) |=> (|(evt_q & $past(cond & ~prev_q & ptr_q))))
		else $error("rising condition did not latch event");
	a_evt_fall_set: assert property (@(posedge clk_sys) disable iff (!resetn) // [R05]
		(|(~cond & prev_q & ntr_q)) |=> (|(evt_q & $past(~cond & prev_q & ntr_q))))
		else $error("falling condition did not latch event");
	a_evt_read_clear: assert property (@(posedge clk_sys) disable iff (!resetn) // [R01]
		(rd_evt && set_bits == '0) |=> (evt_q == '0))
		else $error("event read did not clear");
	a_evt_cls_clear: assert property (@(posedge clk_sys) disable iff (!resetn) // [R16]
		(cls && set_bits == '0) |=> (evt_q == '0))
		else $error("clear status left events");
	a_preset_all_ones: assert property (@(posedge clk_sys) disable iff (!resetn) // [R11]
		preset |=> (en_q == SST_EN_RST))
		else $error("preset did not restore enable");
	a_summary_masked: assert property (@(posedge clk_sys) disable iff (!resetn) // [R20]
		summary == (|(view.event_r & view.enable)))
		else $error("summary not masked OR of events");
endmodule
`default_nettype wire

/* File: rtl/sst_queue.sv */
/*
 Filtered reporting queue of event and error codes: codes pass only when
 listed in an enabled filter entry; a read pops the oldest entry.
 Assumes pushes come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sst_queue (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Code source
	input wire logic push,
	input wire logic [15:0] code,
	// Filter configuration: bit 16 marks an entry in use
	input wire logic filt_wr,
	input wire logic [1:0] filt_idx,
	input wire logic [16:0] filt_data,
	output logic [16:0] filt_view [sst_pkg::SST_QFILT],
	// Consumer
	input wire logic pop,
	input wire logic cls,
	output logic [15:0] head,
	output logic not_empty
);
	import sst_pkg::*;

	logic [15:0] mem_q [SST_QDEPTH];
	logic [16:0] filt_q [SST_QFILT];
	logic [2:0] rp_q, wp_q;
	logic [3:0] cnt_q;
	logic listed, full, do_push, do_pop;

	always_comb
	begin
		listed = 1'b0;
		for (int i = 0; i < SST_QFILT; i++)
			if (filt_q[i][16] && filt_q[i][15:0] == code)
				listed = 1'b1; // [R12]
	end

	assign full = cnt_q == 4'(SST_QDEPTH);
	assign not_empty = cnt_q != 4'h0;
	assign do_push = push && listed && !full && !cls; // [R12]
	assign do_pop = pop && not_empty && !cls; // [R13]
	assign head = not_empty ? mem_q[rp_q] : SST_QEMPTY_CODE;
	assign filt_view = filt_q;

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			rp_q <= '0;
			wp_q <= '0;
			cnt_q <= '0;
		end
		else if (cls)
		begin
			rp_q <= '0;
			wp_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			rp_q <= rp_q + 3'(do_pop);
			wp_q <= wp_q + 3'(do_push);
			cnt_q <= cnt_q + 4'(do_push) - 4'(do_pop);
		end
	end

	always_ff @(posedge clk_sys)
		if (do_push)
			mem_q[wp_q] <= code;

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			for (int i = 0; i < SST_QFILT; i++)
				filt_q[i] <= '0;
		else if (filt_wr)
			filt_q[filt_idx] <= filt_data;
	end

	a_queue_filter_drop: assert property (@(posedge clk_sys) disable iff (!resetn) // [R12]
		(push && !listed && !pop && !cls) |=> $stable(cnt_q))
		else $error("unlisted code entered the queue");
	a_queue_pop_oldest: assert property (@(posedge clk_sys) disable iff (!resetn) // [R13]
		(pop && not_empty && !push && !cls) |=> (cnt_q == $past(cnt_q) - 4'h1))
		else $error("queue read did not remove entry");
endmodule
`default_nettype wire

/* File: rtl/sst_tree.sv */
/*
 Top of the status event tree: five status nodes, the top-level event
 map, the filtered reporting queue and the software register port.
 Assumes slot summaries and ground closure lines arrive asynchronously,
 device conditions and queue codes come from logic on clk_sys.
*/
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Function
// R01: Reading an event register returns latched bits and clears them.
// R02: Reading a condition register shows live state, changes nothing.
// R03: Enable mask selects per bit which events reach the parent summary.
// R04: Positive filter bit set: rising condition latches the event bit.
// R05: Negative filter bit set: falling condition latches the event bit.
// R06: Top level only: any event source may be mapped to any bit.
// R07: Each per-slot summary register bit stands for one module slot.
// R08: Per-slot register summary drives bit 13 of its parent.
// R09: Each plug-in module keeps its own operational and questionable summaries.
// R10: Ground closure node reflects the ground closure port lines.
// R11: Preset sets every enable mask to all ones.
// R12: Queue admits only explicitly enabled codes.
// R13: Queue read returns and removes the oldest entry.
// R14: Operation branch carries settling, calibration and running sequence events.
// R15: Questionable branch carries conditions that may spoil signal quality.
// R16: Clear status also clears every event register.
// R17: Fifteen active bits, top bit zero; enables reset to 32767.
// R18: Positive filters reset to all ones; slot registers design-defined.
// R19: Negative filters reset to all zeros; slot registers design-defined.
// R20: Summary is OR of event bits ANDed with enable bits.
module sst_tree (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// Device conditions
	input wire sst_pkg::sst_bits_t oper_cond_in,
	input wire sst_pkg::sst_bits_t ques_cond_in,
	// Plug-in slot summaries, asynchronous
	input wire sst_pkg::sst_bits_t slot_oper_sum,
	input wire sst_pkg::sst_bits_t slot_ques_sum,
	// Ground closure port lines, asynchronous
	input wire sst_pkg::sst_bits_t ground_closure_lines,
	// Error and event codes
	input wire logic code_push,
	input wire logic [15:0] code_in,
	// Summaries
	output logic oper_summary,
	output logic ques_summary,
	output logic queue_not_empty
);
	import sst_pkg::*;

	localparam int N_NODE = 5;
	localparam int ND_OPER = 0;
	localparam int ND_OPER_INST = 1;
	localparam int ND_GCLO = 2;
	localparam int ND_QUES = 3;
	localparam int ND_QUES_INST = 4;

	// Two-stage synchronisers for pin inputs
	sst_bits_t so_m_q, so_q, sq_m_q, sq_q, gc_m_q, gc_q;

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			so_m_q <= '0;
			so_q <= '0;
			sq_m_q <= '0;
			sq_q <= '0;
			gc_m_q <= '0;
			gc_q <= '0;
		end
		else
		begin
			so_m_q <= slot_oper_sum;
			so_q <= so_m_q;
			sq_m_q <= slot_ques_sum;
			sq_q <= sq_m_q;
			gc_m_q <= ground_closure_lines;
			gc_q <= gc_m_q;
		end
	end

	// Address decode
	logic [2:0] fld;
	logic [3:0] node_sel;
	logic in_nodes, is_cmd, is_qnext, is_qfilt, is_omap, is_qmap;
	assign fld = addr[2:0];
	assign node_sel = addr[6:3];
	assign in_nodes = addr < SST_ADDR_QUEUE_NEXT && fld <= SST_FLD_NTR;
	assign is_cmd = addr == SST_ADDR_CMD;
	assign is_qnext = addr == SST_ADDR_QUEUE_NEXT;
	assign is_qfilt = addr[7:2] == SST_ADDR_QFILT[7:2];
	assign is_omap = addr[7:4] == SST_ADDR_OPER_MAP[7:4] && addr[3:0] != 4'hf;
	assign is_qmap = addr[7:4] == SST_ADDR_QUES_MAP[7:4] && addr[3:0] != 4'hf;

	logic cls, preset;
	assign cls = wr && is_cmd && wdata[SST_CMD_CLS]; // [R16]
	assign preset = wr && is_cmd && wdata[SST_CMD_PRESET]; // [R11]

	// Node wiring
	sst_node_s view [N_NODE];
	sst_cfg_s cfg [N_NODE];
	sst_bits_t cond [N_NODE];
	logic [N_NODE-1:0] summ, rd_evt;

	for (genvar n = 0; n < N_NODE; n++)
	begin : g_dec
		assign cfg[n] = '{wr: wr && in_nodes && node_sel == 4'(n), fld: fld,
			data: wdata[14:0]}; // [R17]
		assign rd_evt[n] = rd && in_nodes && node_sel == 4'(n)
			&& fld == SST_FLD_EVENT; // [R01]
	end

	// Slot bits are one slot each, ground closure bits one port line each, all after the two-stage synchronisers
	assign cond[ND_OPER_INST] = so_q; // [R07] [R09]
	assign cond[ND_QUES_INST] = sq_q; // [R07] [R09]
	assign cond[ND_GCLO] = gc_q; // [R10]

	// Top-level event map
	logic [5:0] omap_q [SST_W];
	logic [5:0] qmap_q [SST_W];
	logic [63:0] pool;
	assign pool = {31'h0000_0000, summ[ND_GCLO], summ[ND_QUES_INST],
		summ[ND_OPER_INST], ques_cond_in, oper_cond_in}; // [R14] [R15] [R08]

	for (genvar b = 0; b < SST_W; b++)
	begin : g_map
		assign cond[ND_OPER][b] = pool[omap_q[b]]; // [R06]
		assign cond[ND_QUES][b] = pool[qmap_q[b]]; // [R06]
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			for (int b = 0; b < SST_W; b++)
			begin
				omap_q[b] <= sst_map_rst(1'b0, b); // [R08]
				qmap_q[b] <= sst_map_rst(1'b1, b); // [R08]
			end
		else if (wr && is_omap)
			omap_q[addr[3:0]] <= wdata[5:0]; // [R06]
		else if (wr && is_qmap)
			qmap_q[addr[3:0]] <= wdata[5:0]; // [R06]
	end

	// Plain nodes take the standard filter defaults
	sst_node #(.PTR_RST(SST_PTR_RST), .NTR_RST(SST_NTR_RST)) u_oper ( // [R18] [R19]
		.clk_sys(clk_sys),
		.resetn(resetn),
		.cond(cond[ND_OPER]),
		.cfg(cfg[ND_OPER]),
		.rd_evt(rd_evt[ND_OPER]),
		.cls(cls),
		.preset(preset),
		.view(view[ND_OPER]),
		.summary(summ[ND_OPER])
	);
	sst_node #(.PTR_RST(SST_PTR_RST), .NTR_RST(SST_NTR_RST)) u_ques ( // [R18] [R19]
		.clk_sys(clk_sys),
		.resetn(resetn),
		.cond(cond[ND_QUES]),
		.cfg(cfg[ND_QUES]),
		.rd_evt(rd_evt[ND_QUES]),
		.cls(cls),
		.preset(preset),
		.view(view[ND_QUES]),
		.summary(summ[ND_QUES])
	);
	sst_node #(.PTR_RST(SST_PTR_RST), .NTR_RST(SST_NTR_RST)) u_gclo (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.cond(cond[ND_GCLO]),
		.cfg(cfg[ND_GCLO]),
		.rd_evt(rd_evt[ND_GCLO]),
		.cls(cls),
		.preset(preset),
		.view(view[ND_GCLO]),
		.summary(summ[ND_GCLO])
	);
	// Slot nodes report both insertion and removal of a module
	sst_node #(.PTR_RST(SST_INST_PTR_RST), .NTR_RST(SST_INST_NTR_RST)) u_oper_inst (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.cond(cond[ND_OPER_INST]),
		.cfg(cfg[ND_OPER_INST]),
		.rd_evt(rd_evt[ND_OPER_INST]),
		.cls(cls),
		.preset(preset),
		.view(view[ND_OPER_INST]),
		.summary(summ[ND_OPER_INST])
	);
	sst_node #(.PTR_RST(SST_INST_PTR_RST), .NTR_RST(SST_INST_NTR_RST)) u_ques_inst (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.cond(cond[ND_QUES_INST]),
		.cfg(cfg[ND_QUES_INST]),
		.rd_evt(rd_evt[ND_QUES_INST]),
		.cls(cls),
		.preset(preset),
		.view(view[ND_QUES_INST]),
		.summary(summ[ND_QUES_INST])
	);

	assign oper_summary = summ[ND_OPER]; // [R20]
	assign ques_summary = summ[ND_QUES]; // [R20]

	// Reporting queue
	logic [16:0] filt_view [SST_QFILT];
	logic [15:0] q_head;
	logic [15:0] q_filt_code;
	logic [15:0] qcode_q;

	sst_queue u_queue (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.push(code_push),
		.code(code_in),
		.filt_wr(wr && is_qfilt),
		.filt_idx(addr[1:0]),
		.filt_data({wdata[0], 16'h0000} | 17'(q_filt_code)),
		.filt_view(filt_view),
		.pop(rd && is_qnext), // [R13]
		.cls(cls),
		.head(q_head),
		.not_empty(queue_not_empty)
	);

	// Filter codes are staged here first, so one write carries the in-use
	// flag in bit 0 while the full 16-bit code comes from the staging register
	assign q_filt_code = qcode_q;
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			qcode_q <= '0;
		else if (wr && addr == SST_ADDR_QFILT + 8'h04)
			qcode_q <= wdata;
	end

	// Read mux
	sst_node_s rv;
	logic [14:0] node_val;
	logic [15:0] rd_val;
	assign rv = view[node_sel < 4'(N_NODE) ? node_sel[2:0] : 3'h0];

	always_comb
	begin
		case (fld)
			SST_FLD_EVENT: node_val = rv.event_r; // [R01]
			SST_FLD_COND: node_val = rv.cond; // [R02]
			SST_FLD_ENABLE: node_val = rv.enable;
			SST_FLD_PTR: node_val = rv.ptr;
			SST_FLD_NTR: node_val = rv.ntr;
			default: node_val = '0;
		endcase
	end

	always_comb
	begin
		rd_val = '0;
		if (in_nodes)
			rd_val = {1'b0, node_val}; // [R17]
		else if (is_qnext)
			rd_val = q_head; // [R13]
		else if (addr == SST_ADDR_QFILT + 8'h04)
			rd_val = qcode_q;
		else if (is_qfilt)
			rd_val = {filt_view[addr[1:0]][16], filt_view[addr[1:0]][14:0]};
		else if (is_omap)
			rd_val = {10'h000, omap_q[addr[3:0]]};
		else if (is_qmap)
			rd_val = {10'h000, qmap_q[addr[3:0]]};
	end

	logic [15:0] rdata_q;
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			rdata_q <= '0;
		else
			rdata_q <= rd ? rd_val : '0;
	end
	assign rdata = rdata_q;

	a_cond_read_pure: assert property (@(posedge clk_sys) disable iff (!resetn) // [R02]
		(rd && in_nodes && fld == SST_FLD_COND) |=> (view[ND_OPER].event_r
			== ($past(view[ND_OPER].event_r) | view[ND_OPER].event_r)))
		else $error("condition read disturbed events");
	a_slot_bit13: assert property (@(posedge clk_sys) disable iff (!resetn) // [R08]
		(omap_q[SST_SLOT_BIT] == SST_POOL_OPER_INST)
			|-> (cond[ND_OPER][SST_SLOT_BIT] == summ[ND_OPER_INST]))
		else $error("slot summary not on bit 13");
	a_slot_sync: assert property (@(posedge clk_sys) disable iff (!resetn) // [R07]
		##2 (cond[ND_OPER_INST] == $past(slot_oper_sum, 2)))
		else $error("slot bit does not follow its slot");
	a_gclo_sync: assert property (@(posedge clk_sys) disable iff (!resetn) // [R10]
		##2 (cond[ND_GCLO] == $past(ground_closure_lines, 2)))
		else $error("ground closure condition does not follow its lines");
	a_top_bit_zero: assert property (@(posedge clk_sys) disable iff (!resetn) // [R17]
		(rd && in_nodes) |=> (rdata[15] == 1'b0))
		else $error("unused top bit read as one");
endmodule
`default_nettype wire

/* File: sim/sst_host_model.sv */
/*
 Remote host model: issues register writes and reads on the strobe port.
 Assumes the tree answers a read in the cycle after the strobe and never waits.
*/
`timescale 1ns/1ps
`default_nettype none
module sst_host_model (
	// Clock
	input wire logic clk_sys,
	// Register port
	output logic [7:0] addr,
	output logic [15:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [15:0] rdata
);
	initial
	begin
		addr = 8'h00;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
	end

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	// Read data stand for one cycle only, so sample mid-cycle
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		@(negedge clk_sys);
		v = rdata;
	endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
/*
 Self-checking bench of the status event tree: reset table, then hand cases.
 Assumes the host model drives the register port on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sst_pkg::*;
	typedef struct {logic [7:0] a; logic [15:0] e;} sst_row_s;
	logic clk_sys, resetn, wr_stb, rd, code_push, oper_summary, ques_summary, queue_not_empty;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, code_in, v;
	sst_bits_t oper_cond_in, ques_cond_in, slot_oper_sum, slot_ques_sum, ground_closure_lines;
	int n_mismatch, checks, cyc;

	function automatic logic [7:0] fa(input logic [7:0] n, input logic [2:0] f);
		return n + {5'h00, f};
	endfunction

	sst_row_s rows[16] = '{
		'{fa(SST_NODE_OPER, SST_FLD_ENABLE), {1'b0, SST_EN_RST}},
		'{fa(SST_NODE_OPER, SST_FLD_PTR), {1'b0, SST_PTR_RST}},
		'{fa(SST_NODE_OPER, SST_FLD_NTR), {1'b0, SST_NTR_RST}},
		'{fa(SST_NODE_OPER, SST_FLD_EVENT), 16'h0000},
		'{fa(SST_NODE_QUES, SST_FLD_ENABLE), {1'b0, SST_EN_RST}},
		'{fa(SST_NODE_QUES, SST_FLD_PTR), {1'b0, SST_PTR_RST}},
		'{fa(SST_NODE_QUES, SST_FLD_NTR), {1'b0, SST_NTR_RST}},
		'{fa(SST_NODE_GCLO, SST_FLD_ENABLE), {1'b0, SST_EN_RST}},
		'{fa(SST_NODE_GCLO, SST_FLD_NTR), {1'b0, SST_NTR_RST}},
		'{fa(SST_NODE_OPER_INST, SST_FLD_NTR), {1'b0, SST_INST_NTR_RST}},
		'{fa(SST_NODE_QUES_INST, SST_FLD_PTR), {1'b0, SST_INST_PTR_RST}},
		'{SST_ADDR_OPER_MAP + 8'h0d, {10'h000, SST_POOL_OPER_INST}},
		'{SST_ADDR_QUES_MAP + 8'h0d, {10'h000, SST_POOL_QUES_INST}},
		'{SST_ADDR_QUES_MAP, {10'h000, SST_POOL_QUES}},
		'{SST_ADDR_QUEUE_NEXT, 16'h0000},
		'{8'h7f, 16'h0000}};

	sst_tree i_sst_tree (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr(wr_stb), .rd(rd), .rdata(rdata), .oper_cond_in(oper_cond_in),
		.ques_cond_in(ques_cond_in), .slot_oper_sum(slot_oper_sum),
		.slot_ques_sum(slot_ques_sum), .ground_closure_lines(ground_closure_lines),
		.code_push(code_push), .code_in(code_in), .oper_summary(oper_summary),
		.ques_summary(ques_summary), .queue_not_empty(queue_not_empty));

	sst_host_model i_sst_host_model (.clk_sys(clk_sys), .addr(addr), .wdata(wdata),
		.wr(wr_stb), .rd(rd), .rdata(rdata));

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		i_sst_host_model.rd_reg(a, v);
		chk(v, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_sst_host_model.wr_reg(a, d);
		// The written register updates at the taking edge, so look after it
		@(negedge clk_sys);
	endtask

	task automatic push(input logic [15:0] c);
		@(posedge clk_sys);
		code_push <= 1'b1;
		code_in <= c;
		@(posedge clk_sys);
		code_push <= 1'b0;
	endtask

	// Hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			conclude();
		end
	end

	initial
	begin
		n_mismatch = 0;
		checks = 0;
		cyc = 0;
		resetn = 1'b0;
		{oper_cond_in, ques_cond_in, slot_oper_sum, slot_ques_sum} = '0;
		ground_closure_lines = '0;
		code_push = 1'b0;
		code_in = 16'h0000;
		repeat (10) @(posedge clk_sys);
		chk({rdata[14:0], oper_summary | ques_summary | queue_not_empty}, 16'h0000);
		resetn <= 1'b1;
		foreach (rows[i])
			rd_chk(rows[i].a, rows[i].e);
		// Rising edges latch, condition reads leave state alone, event read clears
		@(posedge clk_sys);
		oper_cond_in <= 15'h0005;
		repeat (5) @(posedge clk_sys);
		rd_chk(fa(SST_NODE_OPER, SST_FLD_COND), 16'h0005);
		rd_chk(fa(SST_NODE_OPER, SST_FLD_COND), 16'h0005);
		chk({15'h0000, oper_summary}, 16'h0001);
		rd_chk(fa(SST_NODE_OPER, SST_FLD_EVENT), 16'h0005);
		rd_chk(fa(SST_NODE_OPER, SST_FLD_EVENT), 16'h0000);
		chk({15'h0000, oper_summary}, 16'h0000);
		// Filters select the edge direction per bit
		wr(fa(SST_NODE_QUES, SST_FLD_PTR), 16'h0001);
		wr(fa(SST_NODE_QUES, SST_FLD_NTR), 16'h0002);
		@(posedge clk_sys);
		ques_cond_in <= 15'h0003;
		repeat (5) @(posedge clk_sys);
		rd_chk(fa(SST_NODE_QUES, SST_FLD_EVENT), 16'h0001);
		@(posedge clk_sys);
		ques_cond_in <= 15'h0000;
		repeat (5) @(posedge clk_sys);
		rd_chk(fa(SST_NODE_QUES, SST_FLD_EVENT), 16'h0002);
		wr(fa(SST_NODE_QUES, SST_FLD_PTR), 16'h7fff);
		// Enable mask gating, preset, clear status
		wr(fa(SST_NODE_OPER, SST_FLD_ENABLE), 16'h0002);
		@(posedge clk_sys);
		oper_cond_in <= 15'h0007;
		repeat (5) @(posedge clk_sys);
		chk({15'h0000, oper_summary}, 16'h0001);
		wr(fa(SST_NODE_OPER, SST_FLD_ENABLE), 16'h0001);
		chk({15'h0000, oper_summary}, 16'h0000);
		wr(SST_ADDR_CMD, 16'h0002);
		chk({15'h0000, oper_summary}, 16'h0001);
		rd_chk(fa(SST_NODE_OPER, SST_FLD_ENABLE), 16'h7fff);
		wr(SST_ADDR_CMD, 16'h0001);
		chk({15'h0000, oper_summary}, 16'h0000);
		rd_chk(fa(SST_NODE_OPER, SST_FLD_EVENT), 16'h0000);
		// Plug-ins raise slot 4 and slot 14 summaries
		@(posedge clk_sys);
		slot_oper_sum <= 15'h0010;
		slot_ques_sum <= 15'h4000;
		repeat (8) @(posedge clk_sys);
		rd_chk(fa(SST_NODE_OPER_INST, SST_FLD_COND), 16'h0010);
		rd_chk(fa(SST_NODE_OPER, SST_FLD_EVENT), 16'h2000);
		chk({15'h0000, ques_summary}, 16'h0001);
		rd_chk(fa(SST_NODE_QUES, SST_FLD_EVENT), 16'h2000);
		chk({15'h0000, ques_summary}, 16'h0000);
		rd_chk(fa(SST_NODE_QUES_INST, SST_FLD_EVENT), 16'h4000);
		// Remap oper bit 2 to the ground closure summary
		wr(SST_ADDR_OPER_MAP + 8'h02, {10'h000, SST_POOL_GCLO});
		rd_chk(SST_ADDR_OPER_MAP + 8'h02, {10'h000, SST_POOL_GCLO});
		@(posedge clk_sys);
		ground_closure_lines <= 15'h0101;
		repeat (8) @(posedge clk_sys);
		rd_chk(fa(SST_NODE_GCLO, SST_FLD_COND), 16'h0101);
		rd_chk(fa(SST_NODE_OPER, SST_FLD_EVENT), 16'h0004);
		// Queue: unlisted codes dropped, oldest listed code first
		push(16'hff06);
		@(posedge clk_sys);
		chk({15'h0000, queue_not_empty}, 16'h0000);
		wr(SST_ADDR_QFILT + 8'h04, 16'hff06);
		wr(SST_ADDR_QFILT, 16'h0001);
		wr(SST_ADDR_QFILT + 8'h04, 16'hff02);
		wr(SST_ADDR_QFILT + 8'h01, 16'h0001);
		rd_chk(SST_ADDR_QFILT, 16'hff06);
		push(16'hff02);
		push(16'h0001);
		push(16'hff06);
		@(posedge clk_sys);
		chk({15'h0000, queue_not_empty}, 16'h0001);
		rd_chk(SST_ADDR_QUEUE_NEXT, 16'hff02);
		rd_chk(SST_ADDR_QUEUE_NEXT, 16'hff06);
		rd_chk(SST_ADDR_QUEUE_NEXT, 16'h0000);
		push(16'hff06);
		wr(SST_ADDR_CMD, 16'h0001);
		@(posedge clk_sys);
		chk({15'h0000, queue_not_empty}, 16'h0000);
		conclude();
	end
endmodule
`default_nettype wire
